// *** rtl/halt_idle_power_save_ctl.sv ***
// halt_idle_power_save_ctl: cpu-halt and light-idle mode control
// assumes cpu, interrupt controller and register master share sys_clk_in
//
// Design decisions made here: the placing of the registers and strobed register access.
`timescale 1ns/1ns
`include "psave_defs.svh"

module halt_idle_power_save_ctl
(
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_b_in,
  // register port
  input wire logic [`PSAVE_ADDR_W-1:0] reg_addr_in,
  input wire logic [`PSAVE_DATA_W-1:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [`PSAVE_DATA_W-1:0] reg_rdata_out,
  // cpu and interrupt controller
  input wire logic halt_req_in,
  input wire psave_pkg::wake_req_type wake_req_in,
  output psave_pkg::wake_res_type wake_res_out,
  // peripheral clock selections
  input wire psave_pkg::clk_cfg_type clk_cfg_in,
  // clock tree and gates
  output psave_pkg::run_en_type run_en_out,
  output psave_pkg::psave_state_type state_out
);

  // ----------------------------------------
  // state record
  // ----------------------------------------
  typedef struct packed {
    psave_pkg::psave_state_type state;
    logic [1:0] mode_sel;
    logic last_branch;
    logic last_ack;
    logic [`PSAVE_DATA_W-1:0] rdata;
    psave_pkg::wake_res_type wake_res;
    psave_pkg::run_en_type run_en;
  } ctl_state_type;

  ctl_state_type state_r;
  ctl_state_type state_nxt;
  psave_pkg::run_en_type run_dec;
  psave_pkg::psave_state_type dec_state;

  // ----------------------------------------
  // enable decoder
  // ----------------------------------------
  // decode on the next state so the gates line up with the state flops
  assign dec_state = state_nxt.state;

  psave_run_gate u_run_gate
  (
    .state_in(dec_state),
    .cfg_in(clk_cfg_in),
    .run_out(run_dec)
  );

  // ----------------------------------------
  // wake decision
  // ----------------------------------------
  logic any_wake;
  logic higher_prio;
  logic do_ack;
  logic do_branch;

  // requests are combinational from the interrupt side, so they act
  // even while the interrupt controller clock is gated
  assign any_wake = wake_req_in.nmi || wake_req_in.maskable;
  // lower number means higher priority
  assign higher_prio = wake_req_in.req_prio < wake_req_in.serv_prio;
  // outside a routine every request is taken whatever its priority
  assign do_ack = wake_req_in.nmi || !wake_req_in.in_service || higher_prio;
  // maskable requests branch only when taken with interrupts on
  assign do_branch = wake_req_in.nmi || (do_ack && wake_req_in.int_enable);

  // ----------------------------------------
  // register writes
  // ----------------------------------------
  logic wr_mode;
  logic wr_ctrl;
  logic trigger;

  assign wr_mode = reg_wr_in && (reg_addr_in == `PSAVE_MODE_SEL_ADDR);
  assign wr_ctrl = reg_wr_in && (reg_addr_in == `PSAVE_CTRL_ADDR);
  // trigger is a one-shot: it is never stored
  assign trigger = wr_ctrl && reg_wdata_in[`PSAVE_TRIGGER_BIT];

  // ----------------------------------------
  // next-state logic
  // ----------------------------------------
  always_comb
  begin
    state_nxt = state_r;
    state_nxt.wake_res = '0;
    state_nxt.rdata = '0;

    // mode select bits
    if (wr_mode)
    begin
      state_nxt.mode_sel[0] = reg_wdata_in[`PSAVE_MODE_LO_BIT];
      state_nxt.mode_sel[1] = reg_wdata_in[`PSAVE_MODE_HI_BIT];
    end

    // mode sequencing
    unique case (state_r.state)
      psave_pkg::st_normal:
      begin
        if (trigger && (state_r.mode_sel == `PSAVE_MODE_LIGHT_IDLE))
        begin
          state_nxt.state = psave_pkg::st_light_idle;
        end
        else if (halt_req_in)
        begin
          // a request already pending ends the halt one cycle later
          state_nxt.state = psave_pkg::st_halt;
        end
      end
      psave_pkg::st_halt, psave_pkg::st_light_idle:
      begin
        if (any_wake)
        begin
          // straight back to normal: the main oscillator never stopped
          state_nxt.state = psave_pkg::st_normal;
          state_nxt.wake_res.wake = 1'b1;
          state_nxt.wake_res.ack = do_ack;
          state_nxt.wake_res.branch = do_branch;
          state_nxt.wake_res.cont = !do_branch;
          state_nxt.last_ack = do_ack;
          state_nxt.last_branch = do_branch;
        end
      end
    endcase

    // registered enables to the clock tree
    state_nxt.run_en = run_dec;

    // read data valid only in the cycle after the strobe
    if (reg_rd_in)
    begin
      unique case (reg_addr_in)
        `PSAVE_MODE_SEL_ADDR:
        begin
          state_nxt.rdata[`PSAVE_MODE_LO_BIT] = state_r.mode_sel[0];
          state_nxt.rdata[`PSAVE_MODE_HI_BIT] = state_r.mode_sel[1];
        end
        `PSAVE_STATUS_ADDR:
        begin
          state_nxt.rdata[`PSAVE_ST_STATE_LSB +: 2] = state_r.state;
          state_nxt.rdata[`PSAVE_ST_BRANCH_BIT] = state_r.last_branch;
          state_nxt.rdata[`PSAVE_ST_ACK_BIT] = state_r.last_ack;
        end
        default:
        begin
          // control register and unmapped addresses read zero
          state_nxt.rdata = '0;
        end
      endcase
    end
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  // reset puts everything in normal run, the same from any mode
  always_ff @(posedge sys_clk_in)
  begin
    if (!rst_b_in)
    begin
      state_r.state <= psave_pkg::st_normal;
      state_r.mode_sel <= `PSAVE_MODE_SEL_RST;
      state_r.last_branch <= 1'b0;
      state_r.last_ack <= 1'b0;
      state_r.rdata <= '0;
      state_r.wake_res <= '0;
      state_r.run_en <= '1;
      state_r.run_en.port_hold <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
    end
  end

  // ----------------------------------------
  // outputs straight from the flops
  // ----------------------------------------
  assign reg_rdata_out = state_r.rdata;
  assign wake_res_out = state_r.wake_res;
  assign run_en_out = state_r.run_en;
  assign state_out = state_r.state;

endmodule // halt_idle_power_save_ctl

// *** rtl/psave_defs.svh ***
// psave_defs.svh: addresses, field positions, reset values and counts
// of the power-save controller; included by the package and the modules
`ifndef PSAVE_DEFS_SVH
`define PSAVE_DEFS_SVH

// ----------------------------------------
// register addresses (word index)
// ----------------------------------------
`define PSAVE_ADDR_W 4
`define PSAVE_MODE_SEL_ADDR 4'h0
`define PSAVE_CTRL_ADDR 4'h1
`define PSAVE_STATUS_ADDR 4'h2

// ----------------------------------------
// field positions
// ----------------------------------------
`define PSAVE_MODE_LO_BIT 0
`define PSAVE_MODE_HI_BIT 1
`define PSAVE_TRIGGER_BIT 0
`define PSAVE_ST_STATE_LSB 0
`define PSAVE_ST_BRANCH_BIT 2
`define PSAVE_ST_ACK_BIT 3

// ----------------------------------------
// values and counts
// ----------------------------------------
`define PSAVE_MODE_LIGHT_IDLE 2'h0
`define PSAVE_MODE_SEL_RST 2'h0
`define PSAVE_DATA_W 8
`define PSAVE_PRIO_W 3
`define PSAVE_TIMERS 5
`define PSAVE_ASYNC_PORTS 3
`define PSAVE_SYNC_PORTS 2

`endif

// *** rtl/psave_pkg.sv ***
// psave_pkg: types shared by the power-save controller modules
// assumes psave_defs.svh is on the include path
`include "psave_defs.svh"

package psave_pkg;

  // ----------------------------------------
  // controller states
  // ----------------------------------------
  typedef enum logic [1:0] {
    st_normal,
    st_halt,
    st_light_idle
  } psave_state_type;

  // ----------------------------------------
  // count clock choices of the peripherals
  // ----------------------------------------
  typedef enum logic [1:0] {
    tsel_secondary,
    tsel_sub,
    tsel_other
  } timer_sel_type;

  typedef enum logic [2:0] {
    isel_fast_div8,
    isel_slow_div8,
    isel_watch_tick,
    isel_sub,
    isel_other
  } interval_sel_type;

  typedef enum logic [1:0] {
    asel_secondary,
    asel_ext,
    asel_other
  } async_sel_type;

  // ----------------------------------------
  // wake requests from the interrupt side
  // ----------------------------------------
  typedef struct packed {
    logic nmi;
    logic maskable;
    logic [`PSAVE_PRIO_W-1:0] req_prio;
    logic [`PSAVE_PRIO_W-1:0] serv_prio;
    logic in_service;
    logic int_enable;
  } wake_req_type;

  // ----------------------------------------
  // clock selections of the peripherals
  // ----------------------------------------
  typedef struct packed {
    logic sub_present;
    timer_sel_type [`PSAVE_TIMERS-1:0] timer_sel;
    interval_sel_type interval_sel;
    logic watch_on_third_divider;
    async_sel_type [`PSAVE_ASYNC_PORTS-1:0] async_sel;
    logic [`PSAVE_SYNC_PORTS-1:0] sync_ext_clk;
  } clk_cfg_type;

  // ----------------------------------------
  // clock and run enables to the clock tree
  // ----------------------------------------
  typedef struct packed {
    logic cpu_clk;
    logic main_osc;
    logic pll;
    logic flash;
    logic periph_clk;
    logic [`PSAVE_TIMERS-1:0] timers;
    logic interval_timer;
    logic watch_timer;
    logic watchdog_unit;
    logic [`PSAVE_ASYNC_PORTS-1:0] async_ports;
    logic [`PSAVE_SYNC_PORTS-1:0] sync_ports;
    logic adc;
    logic two_wire_port;
    logic fieldbus_controller;
    logic intc;
    logic key_int;
    logic clk_monitor;
    logic port_hold;
  } run_en_type;

  // ----------------------------------------
  // wake result towards the cpu
  // ----------------------------------------
  typedef struct packed {
    logic wake;
    logic ack;
    logic branch;
    logic cont;
  } wake_res_type;

endpackage

// *** rtl/psave_run_gate.sv ***
// psave_run_gate: decodes clock and run enables from the controller state
// assumes clock selections are stable config levels on the system clock
`timescale 1ns/1ns
`include "psave_defs.svh"

module psave_run_gate
(
  // state and configuration
  input wire psave_pkg::psave_state_type state_in,
  input wire psave_pkg::clk_cfg_type cfg_in,
  // decoded enables
  output psave_pkg::run_en_type run_out
);

  logic idle;
  logic halt;

  assign idle = (state_in == psave_pkg::st_light_idle);
  assign halt = (state_in == psave_pkg::st_halt);

  // ----------------------------------------
  // clocks and fixed-rule blocks
  // ----------------------------------------
  assign run_out.cpu_clk = !idle && !halt;
  assign run_out.main_osc = 1'b1;
  assign run_out.pll = 1'b1;
  assign run_out.flash = 1'b1;
  assign run_out.periph_clk = !idle;
  assign run_out.adc = !idle;
  assign run_out.two_wire_port = !idle;
  assign run_out.fieldbus_controller = !idle;
  assign run_out.intc = !idle;
  assign run_out.watchdog_unit = 1'b1;
  assign run_out.key_int = 1'b1;
  assign run_out.clk_monitor = 1'b1;
  assign run_out.port_hold = idle;

  // ----------------------------------------
  // general timers, async ports and sync ports, per unit
  // ----------------------------------------
  genvar i;
  generate
    for (i = 0; i < `PSAVE_TIMERS; i++)
    begin : g_timer
      // odd timers may also count from the sub clock
      assign run_out.timers[i] = !idle
        || (cfg_in.timer_sel[i] == psave_pkg::tsel_secondary)
        || (cfg_in.sub_present && (i % 2 == 1) && (cfg_in.timer_sel[i] == psave_pkg::tsel_sub));
    end
    for (i = 0; i < `PSAVE_ASYNC_PORTS; i++)
    begin : g_async
      // only port 0 has an external clock pin
      assign run_out.async_ports[i] = !idle
        || (cfg_in.async_sel[i] == psave_pkg::asel_secondary)
        || ((i == 0) && (cfg_in.async_sel[i] == psave_pkg::asel_ext));
    end
    for (i = 0; i < `PSAVE_SYNC_PORTS; i++)
    begin : g_sync
      assign run_out.sync_ports[i] = !idle || cfg_in.sync_ext_clk[i];
    end
  endgenerate

  // ----------------------------------------
  // interval and watch timers
  // ----------------------------------------
  assign run_out.interval_timer = !idle
    || (cfg_in.interval_sel == psave_pkg::isel_fast_div8)
    || (cfg_in.interval_sel == psave_pkg::isel_slow_div8)
    || (cfg_in.interval_sel == psave_pkg::isel_watch_tick)
    || (cfg_in.sub_present && cfg_in.interval_sel == psave_pkg::isel_sub);
  assign run_out.watch_timer = !idle || cfg_in.sub_present || cfg_in.watch_on_third_divider;

endmodule // psave_run_gate

// *** bench/halt_idle_power_save_ctl_asserts.sv ***
// checker: port rules of the power-save controller
// assumes it is bound into halt_idle_power_save_ctl
`timescale 1ns/1ns
`include "psave_defs.svh"

module psave_checker
(
  // clock, reset, register writes
  input wire logic sys_clk_in,
  input wire logic rst_b_in,
  input wire logic [`PSAVE_ADDR_W-1:0] reg_addr_in,
  input wire logic [`PSAVE_DATA_W-1:0] reg_wdata_in,
  input wire logic reg_wr_in,
  // cpu side and clock tree
  input wire logic halt_req_in,
  input wire psave_pkg::wake_req_type wake_req_in,
  input wire psave_pkg::wake_res_type wake_res_out,
  input wire psave_pkg::clk_cfg_type clk_cfg_in,
  input wire psave_pkg::run_en_type run_en_out,
  input wire psave_pkg::psave_state_type state_out
);
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rst_b_in);
  logic [1:0] mode_r;
  logic sleep;
  logic idle;
  assign sleep = state_out != psave_pkg::st_normal;
  assign idle = state_out == psave_pkg::st_light_idle;
  // shadow of the mode select bits
  always_ff @(posedge sys_clk_in)
    if (!rst_b_in)
      mode_r <= 2'h0;
    else if (reg_wr_in && reg_addr_in == 4'h0)
      mode_r <= reg_wdata_in[1:0];

  property p_halt_in;
    !sleep && halt_req_in && !reg_wr_in |=> state_out == psave_pkg::st_halt;
  endproperty
  a_halt_in: assert property (p_halt_in) else $error("halt not entered");
  property p_halt_clk;
    state_out == psave_pkg::st_halt |-> !run_en_out.cpu_clk && run_en_out.periph_clk && run_en_out.adc;
  endproperty
  a_halt_clk: assert property (p_halt_clk) else $error("halt clocks wrong");
  property p_idle_clk;
    idle |-> run_en_out.main_osc && run_en_out.pll && run_en_out.flash && !run_en_out.cpu_clk
      && !run_en_out.periph_clk;
  endproperty
  a_idle_clk: assert property (p_idle_clk) else $error("idle clocks wrong");
  property p_idle_keep;
    idle |-> run_en_out.port_hold && run_en_out.watchdog_unit && run_en_out.key_int && run_en_out.clk_monitor
      && !run_en_out.adc && !run_en_out.two_wire_port && !run_en_out.fieldbus_controller && !run_en_out.intc;
  endproperty
  a_idle_keep: assert property (p_idle_keep) else $error("idle units wrong");
  property p_wake;
    sleep && (wake_req_in.nmi || wake_req_in.maskable) |=> !sleep && wake_res_out.wake;
  endproperty
  a_wake: assert property (p_wake) else $error("no wake");
  property p_ack;
    sleep && (wake_req_in.nmi || wake_req_in.maskable && (!wake_req_in.in_service
      || wake_req_in.req_prio < wake_req_in.serv_prio)) |=> wake_res_out.ack;
  endproperty
  a_ack: assert property (p_ack) else $error("no ack");
  property p_nack;
    sleep && !wake_req_in.nmi && wake_req_in.maskable && wake_req_in.in_service
      && wake_req_in.req_prio >= wake_req_in.serv_prio |=> wake_res_out.wake && !wake_res_out.ack;
  endproperty
  a_nack: assert property (p_nack) else $error("low request acked");
  property p_nmi_br;
    sleep && wake_req_in.nmi |=> wake_res_out.branch && !wake_res_out.cont;
  endproperty
  a_nmi_br: assert property (p_nmi_br) else $error("nmi no branch");
  property p_di_cont;
    sleep && !wake_req_in.nmi && wake_req_in.maskable && !wake_req_in.int_enable |=> wake_res_out.cont
      && !wake_res_out.branch;
  endproperty
  a_di_cont: assert property (p_di_cont) else $error("disabled wake branched");
  property p_pulse;
    wake_res_out.wake |=> !wake_res_out.wake;
  endproperty
  a_pulse: assert property (p_pulse) else $error("wake too long");
  property p_reset;
    $rose(rst_b_in) |-> !sleep && !run_en_out.port_hold && !wake_res_out.wake;
  endproperty
  a_reset: assert property (p_reset) else $error("reset state wrong");
  property p_idle_in;
    !sleep && reg_wr_in && reg_addr_in == 4'h1 && reg_wdata_in[0] |=> idle == (mode_r == 2'h0);
  endproperty
  a_idle_in: assert property (p_idle_in) else $error("idle entry wrong");
  property p_sync;
    idle |-> run_en_out.sync_ports == clk_cfg_in.sync_ext_clk;
  endproperty
  a_sync: assert property (p_sync) else $error("sync port run wrong");
  property p_watch;
    idle |-> run_en_out.watch_timer == (clk_cfg_in.sub_present || clk_cfg_in.watch_on_third_divider);
  endproperty
  a_watch: assert property (p_watch) else $error("watch run wrong");
endmodule // psave_checker

bind halt_idle_power_save_ctl psave_checker i_psave_checker (.sys_clk_in(sys_clk_in), .rst_b_in(rst_b_in),
  .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .halt_req_in(halt_req_in),
  .wake_req_in(wake_req_in), .wake_res_out(wake_res_out), .clk_cfg_in(clk_cfg_in), .run_en_out(run_en_out),
  .state_out(state_out));

// *** bench/cpu_irq_model.sv ***
// model of the cpu core and interrupt controller
// assumes it shares sys_clk_in with the controller
`timescale 1ns/1ns

module cpu_irq_model
(
  // clock and wake result
  input wire logic sys_clk_in,
  input wire psave_pkg::wake_res_type wake_res_in,
  // halt and wake requests
  output logic halt_req_out,
  output psave_pkg::wake_req_type wake_req_out
);
  // quiet at time zero
  initial
  begin
    halt_req_out = 1'b0;
    wake_req_out = '0;
  end
  // acknowledged request retires, others stay held
  always @(posedge sys_clk_in)
    if (wake_res_in.ack)
      wake_req_out <= '0;
  // halt instruction, one cycle
  task sleep();
    @(posedge sys_clk_in);
    halt_req_out <= 1'b1;
    @(posedge sys_clk_in);
    halt_req_out <= 1'b0;
    #1;
  endtask
  // raise or drop a request
  task post(input psave_pkg::wake_req_type r);
    @(posedge sys_clk_in);
    wake_req_out <= r;
  endtask
endmodule // cpu_irq_model

// *** bench/halt_idle_power_save_ctl_tb_top.sv ***
// bench: halt and light-idle scenarios
// assumes checker and cpu model compiled alongside
`timescale 1ns/1ns

module halt_idle_power_save_ctl_tb_top;
  logic sys_clk_in, rst_b_in, reg_wr_in, reg_rd_in, halt_req_in;
  logic [3:0] reg_addr_in;
  logic [7:0] reg_wdata_in, reg_rdata_out, d;
  psave_pkg::wake_req_type wake_req_in;
  psave_pkg::wake_res_type wake_res_out;
  psave_pkg::clk_cfg_type clk_cfg_in;
  psave_pkg::run_en_type run_en_out;
  psave_pkg::psave_state_type state_out;
  int n_mismatch, comparisons;

  halt_idle_power_save_ctl i_halt_idle_power_save_ctl (.sys_clk_in(sys_clk_in), .rst_b_in(rst_b_in),
    .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_rdata_out(reg_rdata_out), .halt_req_in(halt_req_in), .wake_req_in(wake_req_in),
    .wake_res_out(wake_res_out), .clk_cfg_in(clk_cfg_in), .run_en_out(run_en_out), .state_out(state_out));
  cpu_irq_model i_cpu_irq_model (.sys_clk_in(sys_clk_in), .wake_res_in(wake_res_out),
    .halt_req_out(halt_req_in), .wake_req_out(wake_req_in));

  // 25 MHz clock
  initial
  begin
    sys_clk_in = 1'b0;
    forever #20 sys_clk_in = ~sys_clk_in;
  end

  task close_out();
    if (n_mismatch == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task cmp(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge sys_clk_in);
    reg_addr_in <= a;
    reg_wdata_in <= v;
    reg_wr_in <= 1'b1;
    @(posedge sys_clk_in);
    reg_wr_in <= 1'b0;
    #1;
  endtask

  task rd(input logic [3:0] a);
    @(posedge sys_clk_in);
    reg_addr_in <= a;
    reg_rd_in <= 1'b1;
    @(posedge sys_clk_in);
    reg_rd_in <= 1'b0;
    #1 d = reg_rdata_out;
  endtask

  // bounded wait for the wake pulse
  task wait_wake();
    int n;
    n = 0;
    while (wake_res_out.wake !== 1'b1 && n < 8)
    begin
      @(posedge sys_clk_in);
      #1;
      n++;
    end
    if (wake_res_out.wake !== 1'b1)
    begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, wake_res_out.wake, 1'b1);
      close_out();
    end
  endtask

  // halt, wake by request, check answer and status
  task t_wake(input psave_pkg::wake_req_type r, input logic a, input logic b);
    i_cpu_irq_model.sleep();
    cmp({state_out, run_en_out.cpu_clk, run_en_out.periph_clk, run_en_out.main_osc, run_en_out.port_hold, 2'h0},
      8'h58);
    i_cpu_irq_model.post(r);
    wait_wake();
    cmp({4'h0, wake_res_out}, {4'h0, 1'b1, a, b, !b});
    rd(4'h2);
    cmp(d, {4'h0, a, b, 2'h0});
    i_cpu_irq_model.post('0);
  endtask

  task t_pending();
    i_cpu_irq_model.post(10'h161);
    i_cpu_irq_model.sleep();
    cmp({6'h0, state_out}, 8'h01);
    wait_wake();
    cmp({6'h0, state_out}, 8'h00);
    i_cpu_irq_model.post('0);
  endtask

  task t_refused();
    wr(4'h0, 8'h01);
    wr(4'h1, 8'h01);
    cmp({6'h0, state_out}, 8'h00);
    rd(4'h0);
    cmp(d, 8'h01);
    rd(4'hF);
    cmp(d, 8'h00);
    wr(4'h0, 8'h00);
  endtask

  task t_idle();
    wr(4'h1, 8'h01);
    cmp({state_out, run_en_out.cpu_clk, run_en_out.periph_clk, run_en_out.main_osc, run_en_out.pll,
      run_en_out.flash, run_en_out.port_hold}, 8'h8F);
    cmp({run_en_out.timers[2:0], run_en_out.sync_ports, run_en_out.watch_timer, run_en_out.watchdog_unit,
      run_en_out.adc}, 8'h6E);
    cmp({run_en_out.two_wire_port, run_en_out.fieldbus_controller, run_en_out.intc, run_en_out.key_int,
      run_en_out.clk_monitor, run_en_out.interval_timer, run_en_out.async_ports[1:0]}, 8'h19);
    repeat (5) @(posedge sys_clk_in);
    i_cpu_irq_model.post(10'h161);
    wait_wake();
    cmp({state_out, run_en_out.cpu_clk, run_en_out.periph_clk, run_en_out.adc, run_en_out.port_hold, 2'h0},
      8'h38);
  endtask

  // light idle without sub clock, other clock choices
  task t_idle_cfg();
    @(posedge sys_clk_in);
    clk_cfg_in.sub_present <= 1'b0;
    clk_cfg_in.timer_sel[0] <= psave_pkg::tsel_other;
    clk_cfg_in.interval_sel <= psave_pkg::isel_watch_tick;
    clk_cfg_in.watch_on_third_divider <= 1'b1;
    clk_cfg_in.async_sel[0] <= psave_pkg::asel_other;
    wr(4'h1, 8'h01);
    cmp({run_en_out.timers, run_en_out.watch_timer, run_en_out.interval_timer, run_en_out.async_ports[2]},
      8'hC7);
    cmp({5'h0, run_en_out.async_ports}, 8'h04);
    i_cpu_irq_model.post(10'h161);
    wait_wake();
    cmp({6'h0, state_out}, 8'h00);
  endtask

  task t_reset_idle();
    wr(4'h1, 8'h01);
    @(posedge sys_clk_in);
    rst_b_in <= 1'b0;
    @(posedge sys_clk_in);
    rst_b_in <= 1'b1;
    #1;
    cmp({state_out, run_en_out.cpu_clk, run_en_out.periph_clk, run_en_out.port_hold, 3'h0}, 8'h30);
  endtask

  // main sequence
  initial
  begin
    rst_b_in = 1'b0;
    reg_wr_in = 1'b0;
    reg_rd_in = 1'b0;
    reg_addr_in = 4'h0;
    reg_wdata_in = 8'h00;
    clk_cfg_in = '0;
    clk_cfg_in.sub_present = 1'b1;
    clk_cfg_in.timer_sel[1] = psave_pkg::tsel_sub;
    clk_cfg_in.timer_sel[2] = psave_pkg::tsel_sub;
    clk_cfg_in.interval_sel = psave_pkg::isel_other;
    clk_cfg_in.async_sel[0] = psave_pkg::asel_ext;
    clk_cfg_in.async_sel[1] = psave_pkg::asel_ext;
    clk_cfg_in.sync_ext_clk = 2'h1;
    n_mismatch = 0;
    comparisons = 0;
    repeat (5) @(posedge sys_clk_in);
    rst_b_in <= 1'b1;
    rd(4'h2);
    cmp(d, 8'h00);
    t_wake(10'h2E2, 1'b1, 1'b1);
    t_wake(10'h161, 1'b1, 1'b1);
    t_wake(10'h160, 1'b1, 1'b0);
    t_wake(10'h1AB, 1'b0, 1'b0);
    t_wake(10'h16F, 1'b0, 1'b0);
    t_wake(10'h12F, 1'b1, 1'b1);
    t_pending();
    t_refused();
    t_idle();
    t_idle_cfg();
    t_reset_idle();
    close_out();
  end
endmodule // halt_idle_power_save_ctl_tb_top
